// File: ssau_regs.vh
`ifndef SSAU_REGS_VH
`define SSAU_REGS_VH

// ------------------------------------------------------------
// scan pacing modes
// ------------------------------------------------------------
`define SSAU_PACE_INTERVAL 2'h0
`define SSAU_PACE_MANUAL 2'h1
`define SSAU_PACE_EXT 2'h2
`define SSAU_PACE_ALARM 2'h3

// ------------------------------------------------------------
// limit modes (cfg data bits [3:2] of the alarm field)
// ------------------------------------------------------------
`define SSAU_LIM_OFF 2'h0
`define SSAU_LIM_HI 2'h1
`define SSAU_LIM_LO 2'h2
`define SSAU_LIM_BOTH 2'h3

// ------------------------------------------------------------
// per-channel configuration fields
// ------------------------------------------------------------
`define SSAU_F_FUNC 3'h0
`define SSAU_F_GAIN 3'h1
`define SSAU_F_OFFSET 3'h2
`define SSAU_F_SCALE_EN 3'h3
`define SSAU_F_ALARM 3'h4
`define SSAU_F_HI 3'h5
`define SSAU_F_LO 3'h6
`define SSAU_F_PATTERN 3'h7
`define SSAU_ALM_NUM_LSB 0
`define SSAU_ALM_MODE_LSB 2

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define SSAU_GAIN_ONE 16'h0100
`define SSAU_GAIN_FRAC 8
`define SSAU_MAX_SWEEPS 16'hC350
`define SSAU_MAX_INTERVAL_H 99
`define SSAU_MAX_INTERVAL_S 19'h57030
`define SSAU_ALQ_DEPTH 5'h14

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SSAU_CLK_NS 10
`define SSAU_SEC_NS 1000000000
`define SSAU_TICKS_PER_SEC (`SSAU_SEC_NS / `SSAU_CLK_NS)

`endif

// File: ssau_mem.v
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// simple dual-port memory, registered read data
// ------------------------------------------------------------
module ssau_mem #(
    parameter W = 16,
    parameter AW = 5
) (
    input wire clk,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [W-1:0] wrData,
    input wire [AW-1:0] rdAddr,
    output reg [W-1:0] rdData
);
    // storage array, no reset: contents are only trusted below a count
    reg [W-1:0] store [0:(1<<AW)-1];

    // write and registered read; read-during-write returns old data
    always @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdData <= store[rdAddr];
    end
endmodule // ssau_mem

`default_nettype wire

// File: ssau_scan_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "ssau_regs.vh"

// Operation
// - four pacing modes: interval, manual, external, alarm
// - interval timed sweep start to start, 0-99h
// - sweep count 1-50000 or continuous, then stop
// - external TTL trigger pulse starts a sweep
// - scaled channels: reading times gain plus offset
// - config change disables scaling, gain one, offset zero
// - scaling kept across preset; factory reset clears
// - null measures channel, stores result as offset
// - four alarms, any channels assigned to each
// - alarm on high, low, or both limits
// - config change disables alarm, clears limits
// - limits default zero; low must not exceed high
// - limits kept across preset; factory reset clears
// - alarm status stored with reading in memory
// - new scan erases previous reading memory
// - alarm queue of twenty with reading and time
// - reading the alarm queue removes entries
// - four alarm lines, latch/track, rising/falling
// - clear command resets all alarm lines
// - digital channel alarms on matching bit pattern
// - two 8-bit ports, live read or scanned
// - per-port binary or decimal number base
module ssau_scan_unit #(
    parameter CW = 3,
    parameter DW = 16,
    parameter RM_AW = 7,
    parameter TICKS_PER_SEC = `SSAU_TICKS_PER_SEC
) (
    input wire clk,
    input wire srst,
    input wire factoryReset,
    input wire cfgWrite,
    input wire [CW-1:0] cfgChan,
    input wire [2:0] cfgField,
    input wire [DW-1:0] cfgData,
    output reg cfgError,
    input wire [1:0] paceMode,
    input wire [18:0] intervalSec,
    input wire [15:0] sweepCount,
    input wire [(1<<CW)-1:0] scanMask,
    input wire scanStart,
    input wire scanStop,
    input wire manualTrig,
    input wire extTrigPin,
    output wire scanBusy,
    output reg [15:0] sweepsDone,
    input wire nullCmd,
    input wire [CW-1:0] nullChan,
    output wire measReq,
    output reg [CW-1:0] measChan,
    input wire measValid,
    input wire [DW-1:0] measData,
    input wire [7:0] dioPortA,
    input wire [7:0] dioPortB,
    input wire [1:0] portBase,
    input wire dioReadReq,
    input wire dioReadSel,
    output reg dioReadValid,
    output reg [11:0] dioReadData,
    input wire [RM_AW-1:0] rmAddr,
    output wire [4+CW+DW-1:0] rmData,
    output reg [RM_AW:0] rmCount,
    input wire alqPop,
    output wire alqValid,
    output wire [24+2+CW+DW-1:0] alqData,
    output reg [4:0] alqCount,
    input wire almLatch,
    input wire almRising,
    input wire almClear,
    output reg [3:0] alarmOut
);
    // ------------------------------------------------------------
    // constants and functions
    // ------------------------------------------------------------
    localparam NCH = 1 << CW;
    localparam RMW = 4 + CW + DW;
    localparam AQW = 24 + 2 + CW + DW;
    localparam [31:0] TPS_M1 = TICKS_PER_SEC - 1;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WAIT = 3'h1;
    localparam [2:0] S_SEL = 3'h2;
    localparam [2:0] S_MEAS = 3'h3;
    localparam [2:0] S_CHECK = 3'h4;
    localparam [2:0] S_NEXT = 3'h5;
    localparam [2:0] S_NULL = 3'h6;

    // gain is signed fixed point with SSAU_GAIN_FRAC fraction bits
    function signed [DW-1:0] fScale;
        input signed [DW-1:0] x;
        input signed [DW-1:0] g;
        input signed [DW-1:0] b;
        reg signed [2*DW-1:0] p;
        begin
            p = x * g;
            p = p >>> `SSAU_GAIN_FRAC;
            fScale = p[DW-1:0] + b;
        end
    endfunction

    // port value in the selected base: binary, or three bcd digits
    function [11:0] fBase;
        input [7:0] v;
        input dec;
        reg [7:0] h;
        reg [7:0] t;
        reg [7:0] o;
        begin
            h = v / 8'h64;
            t = (v % 8'h64) / 8'h0A;
            o = v % 8'h0A;
            fBase = dec ? {h[3:0], t[3:0], o[3:0]} : {4'h0, v};
        end
    endfunction

    // alarm queue pointer wraps at the queue depth
    function [4:0] fInc20;
        input [4:0] p;
        begin
            fInc20 = (p == `SSAU_ALQ_DEPTH - 5'h01) ? 5'h00 : p + 5'h01;
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [7:0] portA1_reg, portA2_reg, portB1_reg, portB2_reg;
    reg ext1_reg, ext2_reg, ext3_reg;

    // two flops per pin; third ext flop only feeds the edge detector
    always @(posedge clk) begin
        portA1_reg <= dioPortA;
        portA2_reg <= portA1_reg;
        portB1_reg <= dioPortB;
        portB2_reg <= portB1_reg;
        ext1_reg <= extTrigPin;
        ext2_reg <= ext1_reg;
        ext3_reg <= ext2_reg;
    end
    wire extRise = ext2_reg & ~ext3_reg;

    // live port read, one cycle after the request
    always @(posedge clk) begin
        if (srst) begin
            dioReadValid <= 1'b0;
            dioReadData <= 12'h000;
        end else begin
            dioReadValid <= dioReadReq;
            if (dioReadReq) begin
                dioReadData <= dioReadSel ? fBase(portB2_reg, portBase[1])
                                          : fBase(portA2_reg, portBase[0]);
            end
        end
    end

    // ------------------------------------------------------------
    // per-channel configuration
    // ------------------------------------------------------------
    reg [DW-1:0] gainMem [0:NCH-1];
    reg [DW-1:0] offMem [0:NCH-1];
    reg [DW-1:0] hiMem [0:NCH-1];
    reg [DW-1:0] loMem [0:NCH-1];
    reg [7:0] patMem [0:NCH-1];
    reg [1:0] almNumMem [0:NCH-1];
    reg [1:0] limModeMem [0:NCH-1];
    reg [NCH-1:0] scaleEn_reg;
    reg [2:0] state_reg;
    integer i;

    wire nullDone = (state_reg == S_NULL) && measValid;
    // a function change or alarm reassignment drops the channel's alarm
    wire cfgDrop = cfgWrite && (cfgField == `SSAU_F_FUNC || cfgField == `SSAU_F_ALARM);

    // srst is power-on only; preset and card reset never reach this block
    always @(posedge clk) begin
        cfgError <= 1'b0;
        if (srst || factoryReset) begin
            for (i = 0; i < NCH; i = i + 1) begin
                gainMem[i] <= `SSAU_GAIN_ONE;
                offMem[i] <= {DW{1'b0}};
                hiMem[i] <= {DW{1'b0}};
                loMem[i] <= {DW{1'b0}};
                patMem[i] <= 8'h00;
                almNumMem[i] <= 2'h0;
                limModeMem[i] <= `SSAU_LIM_OFF;
            end
            scaleEn_reg <= {NCH{1'b0}};
        end else begin
            if (nullDone) begin
                offMem[measChan] <= measData;
            end
            if (cfgWrite) begin
                case (cfgField)
                    `SSAU_F_FUNC: begin
                        scaleEn_reg[cfgChan] <= 1'b0;
                        gainMem[cfgChan] <= `SSAU_GAIN_ONE;
                        offMem[cfgChan] <= {DW{1'b0}};
                        limModeMem[cfgChan] <= `SSAU_LIM_OFF;
                        hiMem[cfgChan] <= {DW{1'b0}};
                        loMem[cfgChan] <= {DW{1'b0}};
                        patMem[cfgChan] <= 8'h00;
                    end
                    `SSAU_F_GAIN: gainMem[cfgChan] <= cfgData;
                    `SSAU_F_OFFSET: offMem[cfgChan] <= cfgData;
                    `SSAU_F_SCALE_EN: scaleEn_reg[cfgChan] <= cfgData[0];
                    `SSAU_F_ALARM: begin
                        almNumMem[cfgChan] <= cfgData[`SSAU_ALM_NUM_LSB+:2];
                        limModeMem[cfgChan] <= cfgData[`SSAU_ALM_MODE_LSB+:2];
                    end
                    `SSAU_F_HI: begin
                        // a high limit below the low limit is refused
                        if ($signed(cfgData) < $signed(loMem[cfgChan])) begin
                            cfgError <= 1'b1;
                        end else begin
                            hiMem[cfgChan] <= cfgData;
                        end
                    end
                    `SSAU_F_LO: begin
                        if ($signed(cfgData) > $signed(hiMem[cfgChan])) begin
                            cfgError <= 1'b1;
                        end else begin
                            loMem[cfgChan] <= cfgData;
                        end
                    end
                    default: patMem[cfgChan] <= cfgData[7:0];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // evaluation of the sampled reading
    // ------------------------------------------------------------
    reg [CW-1:0] curChan_reg;
    reg [DW-1:0] raw_reg;
    wire isDig = (curChan_reg >= NCH - 2); // top two channels are the ports
    wire [7:0] portVal = curChan_reg[0] ? portB2_reg : portA2_reg;
    wire [11:0] portOut = fBase(portVal, portBase[curChan_reg[0]]);
    wire [1:0] curMode = limModeMem[curChan_reg];
    wire [DW-1:0] scaled = (scaleEn_reg[curChan_reg] && !isDig) ?
        fScale(raw_reg, gainMem[curChan_reg], offMem[curChan_reg]) : raw_reg;
    wire [DW-1:0] value = isDig ? {{(DW-12){1'b0}}, portOut} : scaled;
    wire hiHit = !isDig && curMode[0] && ($signed(scaled) > $signed(hiMem[curChan_reg]));
    wire loHit = !isDig && curMode[1] && ($signed(scaled) < $signed(loMem[curChan_reg]));
    wire patHit = isDig && (curMode != `SSAU_LIM_OFF) && (portVal == patMem[curChan_reg]);
    wire alarmNow = hiHit || loHit || patHit;
    wire inCheck = (state_reg == S_CHECK);
    wire almEvent = inCheck && alarmNow;

    // ------------------------------------------------------------
    // reading memory and alarm queue
    // ------------------------------------------------------------
    reg [23:0] timeSec_reg;
    reg [4:0] alqHead_reg, alqTail_reg;
    reg alqFresh_reg;
    wire rmFull = rmCount[RM_AW];
    wire rmWrite = inCheck && !rmFull;
    wire alqPush = almEvent && (alqCount < `SSAU_ALQ_DEPTH);
    wire alqTake = alqPop && alqValid;
    // registered read lags a head move or first write by one cycle
    assign alqValid = (alqCount != 5'h00) && !alqFresh_reg;

    ssau_mem #(.W(RMW), .AW(RM_AW)) uReadMem (
        .clk(clk),
        .wrEn(rmWrite),
        .wrAddr(rmCount[RM_AW-1:0]),
        .wrData({hiHit | patHit, loHit, almNumMem[curChan_reg], curChan_reg, value}),
        .rdAddr(rmAddr),
        .rdData(rmData)
    );

    ssau_mem #(.W(AQW), .AW(5)) uAlarmQueue (
        .clk(clk),
        .wrEn(alqPush),
        .wrAddr(alqTail_reg),
        .wrData({timeSec_reg, almNumMem[curChan_reg], curChan_reg, value}),
        .rdAddr(alqHead_reg),
        .rdData(alqData)
    );

    // queue pointers; when full, further alarms are not logged
    always @(posedge clk) begin
        if (srst) begin
            alqHead_reg <= 5'h00;
            alqTail_reg <= 5'h00;
            alqCount <= 5'h00;
            alqFresh_reg <= 1'b0;
        end else begin
            alqFresh_reg <= alqPush || alqTake;
            if (alqPush) begin
                alqTail_reg <= fInc20(alqTail_reg);
            end
            if (alqTake) begin
                alqHead_reg <= fInc20(alqHead_reg);
            end
            if (alqPush && !alqTake) begin
                alqCount <= alqCount + 5'h01;
            end else if (alqTake && !alqPush) begin
                alqCount <= alqCount - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // timers: free-running time stamp and interval pacing
    // ------------------------------------------------------------
    reg [31:0] freeTick_reg, ivTick_reg;
    reg [18:0] ivSec_reg;
    wire sweepGo;
    wire [18:0] ivLimit = (intervalSec > `SSAU_MAX_INTERVAL_S) ?
                          `SSAU_MAX_INTERVAL_S : intervalSec;

    // interval restarts at each sweep start, so it spans start to start
    always @(posedge clk) begin
        if (srst) begin
            freeTick_reg <= 32'h00000000;
            timeSec_reg <= 24'h000000;
            ivTick_reg <= 32'h00000000;
            ivSec_reg <= 19'h00000;
        end else begin
            if (freeTick_reg == TPS_M1) begin
                freeTick_reg <= 32'h00000000;
                timeSec_reg <= timeSec_reg + 24'h000001;
            end else begin
                freeTick_reg <= freeTick_reg + 32'h00000001;
            end
            if (sweepGo) begin
                ivTick_reg <= 32'h00000000;
                ivSec_reg <= 19'h00000;
            end else if (ivTick_reg == TPS_M1) begin
                ivTick_reg <= 32'h00000000;
                if (ivSec_reg != `SSAU_MAX_INTERVAL_S) begin
                    ivSec_reg <= ivSec_reg + 19'h00001;
                end
            end else begin
                ivTick_reg <= ivTick_reg + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    reg alarmPend_reg;
    reg [15:0] sweepTarget_reg;
    reg trig;

    // pacing source selection
    always @* begin
        case (paceMode)
            `SSAU_PACE_INTERVAL: trig = (ivSec_reg >= ivLimit);
            `SSAU_PACE_MANUAL: trig = manualTrig;
            `SSAU_PACE_EXT: trig = extRise;
            default: trig = alarmPend_reg;
        endcase
    end
    // interval mode starts its first sweep on the start command itself
    assign sweepGo = ((state_reg == S_WAIT) && trig && !scanStop) ||
                     ((state_reg == S_IDLE) && scanStart &&
                      (paceMode == `SSAU_PACE_INTERVAL));
    assign scanBusy = (state_reg != S_IDLE) && (state_reg != S_NULL);
    assign measReq = (state_reg == S_MEAS) || (state_reg == S_NULL);

    // main sweep state machine
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= S_IDLE;
            curChan_reg <= {CW{1'b0}};
            measChan <= {CW{1'b0}};
            raw_reg <= {DW{1'b0}};
            rmCount <= {(RM_AW+1){1'b0}};
            sweepsDone <= 16'h0000;
            sweepTarget_reg <= 16'h0000;
            alarmPend_reg <= 1'b0;
        end else begin
            if (rmWrite) begin
                rmCount <= rmCount + 1'b1;
            end
            if (sweepGo) begin
                alarmPend_reg <= 1'b0;
                curChan_reg <= {CW{1'b0}};
                state_reg <= S_SEL;
            end
            if (almEvent) begin
                alarmPend_reg <= 1'b1; // set wins over the sweep-start clear
            end
            case (state_reg)
                S_IDLE: begin
                    if (scanStart) begin
                        rmCount <= {(RM_AW+1){1'b0}};
                        sweepsDone <= 16'h0000;
                        // zero is continuous; beyond the maximum is clamped
                        sweepTarget_reg <= (sweepCount > `SSAU_MAX_SWEEPS) ?
                                           `SSAU_MAX_SWEEPS : sweepCount;
                        if (paceMode != `SSAU_PACE_INTERVAL) begin
                            state_reg <= S_WAIT;
                        end
                    end else if (nullCmd) begin
                        measChan <= nullChan;
                        state_reg <= S_NULL;
                    end
                end
                S_WAIT: begin
                    if (scanStop) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_SEL: begin
                    if (!scanMask[curChan_reg]) begin
                        state_reg <= S_NEXT;
                    end else if (isDig) begin
                        state_reg <= S_CHECK;
                    end else begin
                        measChan <= curChan_reg;
                        state_reg <= S_MEAS;
                    end
                end
                S_MEAS: begin
                    if (measValid) begin
                        raw_reg <= measData;
                        state_reg <= S_CHECK;
                    end
                end
                S_CHECK: state_reg <= S_NEXT;
                S_NEXT: begin
                    if (curChan_reg != NCH - 1) begin
                        curChan_reg <= curChan_reg + 1'b1;
                        state_reg <= S_SEL;
                    end else begin
                        sweepsDone <= sweepsDone + 16'h0001;
                        if (sweepTarget_reg != 16'h0000 &&
                            sweepsDone + 16'h0001 == sweepTarget_reg) begin
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_WAIT;
                        end
                    end
                end
                S_NULL: begin
                    if (measValid) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
            if (scanStop && scanBusy) begin
                state_reg <= S_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm output lines
    // ------------------------------------------------------------
    reg [NCH-1:0] inAlarm_reg;
    reg [3:0] latch_reg;
    reg [3:0] trackCond;
    reg [3:0] active;
    integer k;

    // current condition per alarm: any assigned channel still in alarm
    always @* begin
        trackCond = 4'h0;
        for (k = 0; k < NCH; k = k + 1) begin
            if (inAlarm_reg[k]) begin
                trackCond[almNumMem[k]] = 1'b1;
            end
        end
        active = almLatch ? latch_reg : trackCond;
    end

    // clear first so a same-cycle alarm event still lands
    always @(posedge clk) begin
        if (srst) begin
            inAlarm_reg <= {NCH{1'b0}};
            latch_reg <= 4'h0;
            alarmOut <= 4'h0;
        end else begin
            if (almClear) begin
                inAlarm_reg <= {NCH{1'b0}};
                latch_reg <= 4'h0;
            end
            if (cfgDrop) begin
                inAlarm_reg[cfgChan] <= 1'b0;
            end
            if (inCheck) begin
                inAlarm_reg[curChan_reg] <= alarmNow;
            end
            if (almEvent) begin
                latch_reg[almNumMem[curChan_reg]] <= 1'b1;
            end
            // rising slope drives high when active, falling drives low
            alarmOut <= almRising ? active : ~active;
        end
    end
endmodule // ssau_scan_unit

`default_nettype wire

// File: ssau_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// measurement front end stand-in
// ------------------------------------------
module ssau_meas_model (
    input wire logic clk,
    input wire logic measReq,
    input wire logic [2:0] measChan,
    output logic measValid = '0,
    output logic [15:0] measData
);
    logic [1:0] waitReg = 2'h0; // slow answer, not single cycle
    // reading is 0x40 plus channel; garbage once valid has gone
    always @(posedge clk) begin
        waitReg <= (measReq && !measValid) ? waitReg + 2'h1 : 2'h0;
        measValid <= measReq && !measValid && waitReg == 2'h2;
        measData <= measValid ? 16'hA5A5 : 16'h0040 + {13'h0, measChan};
    end
endmodule // ssau_meas_model
`default_nettype wire

// File: ssau_scan_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// port checks for the scan unit
// ------------------------------------------
module ssau_scan_monitor #(parameter RM_AW = 7) (
    input wire logic clk,
    input wire logic srst,
    input wire logic cfgWrite,
    input wire logic [2:0] cfgField,
    input wire logic cfgError,
    input wire logic scanStart,
    input wire logic scanStop,
    input wire logic scanBusy,
    input wire logic [RM_AW:0] rmCount,
    input wire logic alqPop,
    input wire logic alqValid,
    input wire logic [4:0] alqCount,
    input wire logic almClear,
    input wire logic almLatch,
    input wire logic almRising,
    input wire logic [3:0] alarmOut,
    input wire logic dioReadReq,
    input wire logic dioReadValid,
    input wire logic measReq,
    input wire logic measValid,
    input wire logic [2:0] measChan
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_err_one_cycle: assert property (cfgError |=> !cfgError)
        else $error("cfgError held too long");
    a_err_from_limit: assert property (cfgError |-> $past(cfgWrite) &&
        $past(cfgField) inside {3'h5, 3'h6}) else $error("cfgError without limit write");
    a_busy_needs_start: assert property ($rose(scanBusy) |-> $past(scanStart))
        else $error("scan began without start");
    a_rm_cleared: assert property (scanStart && !scanBusy && !measReq |=> rmCount == 0)
        else $error("reading memory kept old scan");
    a_queue_bound: assert property (alqCount <= 5'h14 && (!alqValid || alqCount != 5'h0))
        else $error("alarm queue count wrong");
    a_pop_removes: assert property (alqPop && alqValid && !scanBusy |=>
        alqCount == $past(alqCount) - 5'h1) else $error("pop did not remove entry");
    a_clear_lines: assert property (almClear && almLatch && almRising && !scanBusy
        |-> ##2 alarmOut == 4'h0) else $error("alarm lines not cleared");
    a_dio_answer: assert property (dioReadReq |=> dioReadValid)
        else $error("live port read not answered");
    a_meas_held: assert property (!scanStop && measReq && !measValid |=>
        measReq && $stable(measChan)) else $error("measure request dropped");
endmodule // ssau_scan_monitor
bind ssau_scan_unit ssau_scan_monitor #(.RM_AW(RM_AW)) u_mon (.*);
`default_nettype wire

// File: ssau_scan_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// scan unit bench
// ------------------------------------------
module ssau_scan_unit_tb;
    logic clk = '0, srst = '1, factoryReset = '0, cfgWrite = '0, scanStart = '0, scanStop = '0;
    logic manualTrig = '0, extTrigPin = '0, nullCmd = '0, dioReadReq = '0, dioReadSel = '0;
    logic alqPop = '0, almLatch = '1, almRising = '1, almClear = '0; // latch, active high
    logic [2:0] cfgChan = 3'h0, cfgField = 3'h0, nullChan = 3'h0, measChan;
    logic [15:0] cfgData = 16'h0, sweepCount = 16'h1, measData, sweepsDone;
    logic [1:0] paceMode = 2'h0, portBase = 2'h2; // port B decimal
    logic [18:0] intervalSec = 19'h0; // back to back sweeps
    logic [7:0] scanMask = 8'h01, dioPortA = 8'h55, dioPortB = 8'hF0, rmCount;
    logic [6:0] rmAddr = 7'h0; // always look at the first reading
    logic cfgError, scanBusy, measReq, measValid, dioReadValid, alqValid;
    logic [11:0] dioReadData;
    logic [22:0] rmData;
    logic [44:0] alqData;
    logic [4:0] alqCount;
    logic [3:0] alarmOut;
    int fail_count = 0, total_checks = 0, cyc = 0;
    ssau_scan_unit #(.TICKS_PER_SEC(10)) dut (.*); // short second keeps runs small
    ssau_meas_model u_meas (.*);
    always #5 clk = ~clk;
    // hang guard: whole run needs under two hundred cycles
    always @(posedge clk) if (++cyc > 5000) begin
        fail_count++;
        tally_and_finish;
    end
    task automatic chk(input string n, input logic [44:0] e, input logic [44:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cfg(input [2:0] c, input [2:0] f, input [15:0] d, input logic e);
        @(posedge clk) {cfgWrite, cfgChan, cfgField, cfgData} <= {1'b1, c, f, d};
        @(posedge clk) cfgWrite <= '0;
        #1 chk("cfgError", e, cfgError);
    endtask
    // start, pulse the manual or external trigger in those modes, wait for idle
    task automatic scan(input [1:0] m, input [15:0] n);
        @(posedge clk) {paceMode, sweepCount, scanStart} <= {m, n, 1'b1};
        @(posedge clk) scanStart <= '0;
        repeat (3) @(posedge clk) {extTrigPin, manualTrig} <= {m == 2'h2, m == 2'h1};
        @(posedge clk) {extTrigPin, manualTrig} <= 2'h0;
        while (scanBusy !== 1'b0) @(posedge clk) #1;
        @(posedge clk) #1 chk("sweepsDone", n, sweepsDone);
    endtask
    task automatic dio(input logic s, input [11:0] e);
        @(posedge clk) {dioReadReq, dioReadSel} <= {1'b1, s};
        @(posedge clk) dioReadReq <= '0;
        #1 chk("dioRead", {1'b1, e}, {dioReadValid, dioReadData});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= '0;
        cfg(3'h0, 3'h1, 16'h0200, '0);
        cfg(3'h0, 3'h2, 16'h0005, '0);
        cfg(3'h0, 3'h3, 16'h0001, '0);
        cfg(3'h0, 3'h5, 16'h0080, '0);
        cfg(3'h0, 3'h4, 16'h0005, '0);
        scan(2'h0, 16'h0001);
        chk("rmData", 23'h480085, rmData);
        chk("alqData", 21'h080085, alqData[20:0]);
        chk("alarmOut", 4'h2, alarmOut);
        @(posedge clk) almClear <= '1;
        @(posedge clk) almClear <= '0;
        @(posedge clk) alqPop <= '1;
        @(posedge clk) alqPop <= '0;
        #1 chk("alarmOut", 4'h0, alarmOut);
        chk("alqCount", 5'h0, alqCount);
        cfg(3'h0, 3'h6, 16'h0100, '1);
        cfg(3'h0, 3'h0, 16'h0001, '0);
        scan(2'h0, 16'h0002);
        chk("rmCount", 8'h02, rmCount);
        chk("reading", 18'h00040, {rmData[22:21], rmData[15:0]});
        cfg(3'h0, 3'h5, 16'h0080, '0);
        @(posedge clk) factoryReset <= '1;
        @(posedge clk) factoryReset <= '0;
        cfg(3'h0, 3'h6, 16'h0010, '1);
        scan(2'h1, 16'h0001);
        scan(2'h2, 16'h0001);
        @(posedge clk) {almLatch, almRising} <= 2'h0;
        @(posedge clk) #1 chk("alarmOut", 4'hF, alarmOut);
        dio('0, 12'h055);
        dio('1, 12'h240);
        tally_and_finish;
    end
endmodule // ssau_scan_unit_tb
`default_nettype wire
